// file: src/tssu_clock_startup.sv
// Two-speed start-up sequencer: runs the core from the internal oscillator
// until the external source is proven, then hands the system clock over.
// Assumes both oscillators arrive as pins, far slower than sys_clk.
//
// Operation
// R1: Restart sequence on reset release or wake.
// R2: Start on internal clock at selected frequency.
// R3: Count 1024 external cycles before switching.
// R4: After timeout, await internal falling edge, set flag.
// R5: Hold clock low until external falling edge; the code skips the hold for TSSU_SRC_EXTC.
// R6: Then switch system clock to external source.
// R7: Flag shows external versus internal source.
// R8: Flag clear while the start-up timer runs.
`timescale 1ns/1ns
module tssu_clock_startup
  import tssu_pkg::*;
#(
  parameter int unsigned STARTUP_CYCLES = TSSU_STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // Wake from sleep, one-cycle pulse on sys_clk
  input  wire logic                   sleep_wake,
  // Oscillator pins
  input  wire logic                   int_osc_in,
  input  wire logic                   ext_osc_in,
  // Configuration
  input  wire logic [TSSU_FREQ_W-1:0] internal_freq_select,
  input  wire logic [TSSU_SRC_W-1:0]  config_clock_source_select,
  // Status and clock control
  output logic                        startup_complete_flag,
  output logic                        clk_sel_ext,
  output logic                        clk_hold_low,
  output logic                        startup_cycle_timer_run,
  output logic [TSSU_FREQ_W-1:0]      core_freq_select
);
  logic [1:0]            pins_sync;
  logic                  int_sync;
  logic                  ext_sync;
  logic                  int_prev_q;
  logic                  int_prev_d;
  logic                  ext_prev_q;
  logic                  ext_prev_d;
  logic                  int_fall;
  logic                  ext_fall;
  logic                  ext_rise;
  logic                  crystal_mode_sel;
  tssu_state_type        state_q;
  tssu_state_type        state_d;
  logic [TSSU_CNT_W-1:0] cnt_q;
  logic [TSSU_CNT_W-1:0] cnt_d;
  logic                  flag_q;
  logic                  flag_d;
  logic                  sel_ext_q;
  logic                  sel_ext_d;
  logic                  hold_q;
  logic                  hold_d;
  logic                  run_q;
  logic                  run_d;
  logic [TSSU_FREQ_W-1:0] freq_q;
  logic [TSSU_FREQ_W-1:0] freq_d;
  logic [TSSU_CNT_W-1:0] cnt_last;

  tssu_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in ({ext_osc_in, int_osc_in}),
    .sync_out (pins_sync)
  );

  assign int_sync = pins_sync[0];
  assign ext_sync = pins_sync[1];
  assign int_fall = int_prev_q & ~int_sync;
  assign ext_fall = ext_prev_q & ~ext_sync;
  assign ext_rise = ~ext_prev_q & ext_sync;
  assign cnt_last = TSSU_CNT_W'(STARTUP_CYCLES - 1);
  // Only crystal-type sources need the hold-low gap
  assign crystal_mode_sel = (config_clock_source_select == TSSU_SRC_LOW_POWER) ||
                            (config_clock_source_select == TSSU_SRC_CRYSTAL) ||
                            (config_clock_source_select == TSSU_SRC_HIGH_SPEED);

  always_comb begin
    int_prev_d = int_sync;
    ext_prev_d = ext_sync;
    state_d    = state_q;
    cnt_d      = cnt_q;
    flag_d     = flag_q;
    sel_ext_d  = sel_ext_q;
    hold_d     = hold_q;
    run_d      = run_q;
    freq_d     = internal_freq_select; // [R2]
    if (sleep_wake) begin
      // Wake restarts from the internal clock, same as reset
      state_d   = (config_clock_source_select == TSSU_SRC_INT) ? TSSU_ST_INT_ONLY : TSSU_ST_COUNT; // [R1]
      cnt_d     = '0;
      flag_d    = 1'b0; // [R8]
      sel_ext_d = 1'b0; // [R2]
      hold_d    = 1'b0;
      run_d     = (config_clock_source_select != TSSU_SRC_INT); // [R3]
    end else begin
      case (state_q)
        TSSU_ST_COUNT: begin
          if (config_clock_source_select == TSSU_SRC_INT) begin
            state_d = TSSU_ST_INT_ONLY;
            run_d   = 1'b0;
          end else if (ext_rise) begin
            if (cnt_q == cnt_last) begin
              state_d = TSSU_ST_WAIT_INT_FALL; // [R3]
              run_d   = 1'b0;
            end else begin
              cnt_d = cnt_q + 1'b1; // [R3]
            end
          end
        end
        TSSU_ST_WAIT_INT_FALL: begin
          if (int_fall) begin
            flag_d = 1'b1; // [R4]
            if (crystal_mode_sel) begin
              state_d = TSSU_ST_HOLD_LOW;
              hold_d  = 1'b1; // [R5]
            end else begin
              state_d   = TSSU_ST_EXT_RUN;
              sel_ext_d = 1'b1; // [R6]
            end
          end
        end
        TSSU_ST_HOLD_LOW: begin
          if (ext_fall) begin
            state_d   = TSSU_ST_EXT_RUN;
            hold_d    = 1'b0;
            sel_ext_d = 1'b1; // [R6]
          end
        end
        TSSU_ST_EXT_RUN: begin
          flag_d = 1'b1; // [R7]
        end
        TSSU_ST_INT_ONLY: begin
          flag_d = 1'b0; // [R7]
        end
        default: begin
          state_d = TSSU_ST_COUNT;
        end
      endcase
    end
  end

  // Reset release starts the sequence on the internal clock
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      int_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      state_q    <= TSSU_ST_COUNT; // [R1]
      cnt_q      <= '0;
      flag_q     <= 1'b0; // [R8]
      sel_ext_q  <= 1'b0;
      hold_q     <= 1'b0;
      run_q      <= 1'b1;
      freq_q     <= TSSU_FREQ_RST;
    end else begin
      int_prev_q <= int_prev_d;
      ext_prev_q <= ext_prev_d;
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      flag_q     <= flag_d;
      sel_ext_q  <= sel_ext_d;
      hold_q     <= hold_d;
      run_q      <= run_d;
      freq_q     <= freq_d;
    end
  end

  assign startup_complete_flag   = flag_q; // [R7]
  assign clk_sel_ext             = sel_ext_q;
  assign clk_hold_low            = hold_q;
  assign startup_cycle_timer_run = run_q;
  assign core_freq_select        = freq_q;
endmodule

// file: src/tssu_pkg.sv
// Constants for the two-speed start-up clock switcher.
// Assumes oscillator pins are sampled on sys_clk by the block itself.
package tssu_pkg;
  localparam int unsigned TSSU_STARTUP_CYCLES = 1024;
  localparam int unsigned TSSU_CNT_W          = 11;
  localparam int unsigned TSSU_FREQ_W         = 4;
  localparam int unsigned TSSU_SRC_W          = 3;
  // Clock source codes; values are our own encoding of the configuration field
  localparam logic [2:0] TSSU_SRC_LOW_POWER  = 3'h0;
  localparam logic [2:0] TSSU_SRC_CRYSTAL    = 3'h1;
  localparam logic [2:0] TSSU_SRC_HIGH_SPEED = 3'h2;
  localparam logic [2:0] TSSU_SRC_EXTC = 3'h3;
  localparam logic [2:0] TSSU_SRC_INT  = 3'h4;
  localparam logic [3:0] TSSU_FREQ_RST = 4'h0;

  typedef enum logic [2:0] {
    TSSU_ST_COUNT,
    TSSU_ST_WAIT_INT_FALL,
    TSSU_ST_HOLD_LOW,
    TSSU_ST_EXT_RUN,
    TSSU_ST_INT_ONLY
  } tssu_state_type;
endpackage

// file: src/tssu_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent level from another clock.
`timescale 1ns/1ns
module tssu_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// file: bench/tssu_ext_osc.sv
// External crystal model: free-running square wave.
// Assumes no phase relation to sys_clk.
`timescale 1ns/1ns
module tssu_ext_osc #(
  parameter int HALF_NS = 97
) (
  output logic osc_out
);
  initial osc_out = 1'b0;
  always #HALF_NS osc_out = ~osc_out;
endmodule

// file: bench/tssu_clock_startup_sva.sv
// Port checker for the start-up switcher.
// Assumes one sys_clk domain.
`timescale 1ns/1ns
module tssu_clock_startup_sva (
  input wire logic       sys_clk, rstn, sleep_wake, int_osc_in, ext_osc_in,
  input wire logic [3:0] internal_freq_select, core_freq_select,
  input wire logic [2:0] config_clock_source_select,
  input wire logic       startup_complete_flag, clk_sel_ext, clk_hold_low, startup_cycle_timer_run
);
  wire fl = startup_complete_flag;
  wire se = clk_sel_ext;
  wire ho = clk_hold_low;
  wire ru = startup_cycle_timer_run;
  wire [2:0] src = config_clock_source_select;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_wake_restart: assert property (sleep_wake && src != 3'h4 |=> ru && !fl && !se && !ho) else $error("no restart");
  a_freq_follow: assert property (1 |=> core_freq_select == $past(internal_freq_select)) else $error("freq");
  a_timer_flag_clear: assert property (ru |-> !fl && !se) else $error("flag early");
  a_flag_after_timer: assert property ($rose(fl) |-> !ru && !$past(ru)) else $error("flag order");
  a_hold_no_ext: assert property (ho |-> !se && fl) else $error("hold");
  a_hold_bounded: assert property (ho |-> ##[1:24] !ho) else $error("hold stuck");
  a_switch_after_hold: assert property ($rose(se) && src <= 3'h2 |-> $past(ho)) else $error("switch");
  a_sel_flag: assert property (se |-> fl) else $error("sel flag");
  a_int_only_clear: assert property (src == 3'h4 |-> ##2 !fl) else $error("int only");
endmodule
bind tssu_clock_startup tssu_clock_startup_sva u_sva (.sys_clk, .rstn, .sleep_wake, .int_osc_in, .ext_osc_in,
  .internal_freq_select, .core_freq_select, .config_clock_source_select, .startup_complete_flag,
  .clk_sel_ext, .clk_hold_low, .startup_cycle_timer_run);

// file: bench/test_tssu_clock_startup.sv
// Bench for the start-up switcher, short count of 8.
// Assumes the crystal model as far side.
`timescale 1ns/1ns
module test_tssu_clock_startup import tssu_pkg::*; ;
  logic       sys_clk = 0, rstn = 0, sleep_wake = 0, int_osc_in = 0;
  logic [3:0] internal_freq_select = 4'h5;
  logic [2:0] config_clock_source_select = TSSU_SRC_CRYSTAL;
  wire        ext_osc_in, startup_complete_flag, clk_sel_ext, clk_hold_low, startup_cycle_timer_run;
  wire  [3:0] core_freq_select;
  int         fails = 0, samples_checked = 0, n, ph = 0;
  initial forever #10 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    ph++;
    if (ph % 3 == 0) int_osc_in <= ~int_osc_in;
  end
  tssu_ext_osc #(.HALF_NS(97)) u_osc (.osc_out(ext_osc_in));
  tssu_clock_startup #(.STARTUP_CYCLES(8)) dut (.sys_clk, .rstn, .sleep_wake, .int_osc_in, .ext_osc_in,
    .internal_freq_select, .config_clock_source_select, .startup_complete_flag, .clk_sel_ext,
    .clk_hold_low, .startup_cycle_timer_run, .core_freq_select);
  task check(string what, logic [3:0] exp, logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h got %h", what, exp, got);
    end
  endtask
  task pulse_wake;
    sleep_wake = 1;
    @(negedge sys_clk) sleep_wake = 0;
  endtask
  task run_seq(logic [2:0] src);
    config_clock_source_select = src;
    pulse_wake;
    check("restart", 4'h1, {clk_sel_ext, clk_hold_low, startup_complete_flag, startup_cycle_timer_run});
    n = 0;
    while (startup_cycle_timer_run === 1'b1 && n < 200) @(negedge sys_clk) n++;
    check("timer_len", 4'h1, 4'(n >= 60 && n <= 100));
    check("flag_early", 4'h0, {3'h0, startup_complete_flag});
    n = 0;
    while (startup_complete_flag !== 1'b1 && n < 20) @(negedge sys_clk) n++;
    check("hold", {3'h0, src != TSSU_SRC_EXTC}, {3'h0, clk_hold_low});
    n = 0;
    while (clk_sel_ext !== 1'b1 && n < 30) @(negedge sys_clk) n++;
    check("switched", 4'h5, {1'b0, clk_sel_ext, clk_hold_low, startup_complete_flag});
  endtask
  task int_only;
    config_clock_source_select = TSSU_SRC_INT;
    pulse_wake;
    repeat (120) @(negedge sys_clk);
    check("int_only", 4'h0, {clk_sel_ext, clk_hold_low, startup_complete_flag, startup_cycle_timer_run});
  endtask
  task freq_follow;
    internal_freq_select = 4'ha;
    @(negedge sys_clk);
    check("core_freq", 4'ha, core_freq_select);
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    results;
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rstn = 1;
    check("por", 4'h1, {clk_sel_ext, clk_hold_low, startup_complete_flag, startup_cycle_timer_run});
    freq_follow;
    for (int s = 0; s < 4; s++) run_seq(3'(s));
    // Wake again after the switch: the count must start over
    pulse_wake;
    repeat (30) @(negedge sys_clk);
    check("midcount", 4'h1, {clk_sel_ext, clk_hold_low, startup_complete_flag, startup_cycle_timer_run});
    run_seq(TSSU_SRC_HIGH_SPEED);
    int_only;
    results;
  end
endmodule
